// [src/rtc_pkg.sv]
/*
  Constants shared by the timekeeping RAM: address map of the clock bytes,
  control bit positions, BCD limits and timing counts.
  Assumes a single 100 MHz clock.
*/
package rtc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam logic [12:0] ADDR_CTRL = 13'h1FF8;
  localparam logic [12:0] ADDR_SEC = 13'h1FF9;
  localparam logic [12:0] ADDR_MIN = 13'h1FFA;
  localparam logic [12:0] ADDR_HOUR = 13'h1FFB;
  localparam logic [12:0] ADDR_DAY = 13'h1FFC;
  localparam logic [12:0] ADDR_DATE = 13'h1FFD;
  localparam logic [12:0] ADDR_MONTH = 13'h1FFE;
  localparam logic [12:0] ADDR_YEAR = 13'h1FFF;
  localparam logic [9:0] CLOCK_BASE = 10'h3FF;
  localparam int BIT_WRITE_HOLD = 7;
  localparam int BIT_READ_HOLD = 6;
  localparam int BIT_OSC_STOP = 7;
  localparam int BIT_FREQ_TEST = 6;
  localparam int BIT_BATT_LOW = 7;
  localparam logic [7:0] MASK_CENT = 8'h3F;
  localparam logic [7:0] MASK_SEC = 8'h7F;
  localparam logic [7:0] MASK_MIN = 8'h7F;
  localparam logic [7:0] MASK_HOUR = 8'h3F;
  localparam logic [7:0] MASK_DAY = 8'h07;
  localparam logic [7:0] MASK_DATE = 8'h3F;
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MAX_SEC = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_DAY = 8'h07;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] MAX_CENT = 8'h39;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] MONTH_FEB = 8'h02;
  localparam int FREQ_TEST_HZ = 512;
  localparam int HALF_TEST_CYCLES = CLK_HZ / (2 * FREQ_TEST_HZ);
  localparam int TICKS_PER_SEC = 2 * FREQ_TEST_HZ;
  localparam int RECOVERY_MS = 200;
  localparam int RECOVERY_CYCLES = RECOVERY_MS * (CLK_HZ / 1000);
  localparam int POR_US = 100;
  localparam int POR_CYCLES = POR_US * (CLK_HZ / 1_000_000);
endpackage : rtc_pkg

// [src/bcd_inc.sv]
/*
  Two-digit BCD increment with wrap to a given low value.
  Assumes well-formed BCD input.
*/
`timescale 1ns/1ns
`default_nettype none
module bcd_inc (
  // Value and limits.
  input wire logic [7:0] val_i,
  input wire logic [7:0] max_i,
  input wire logic [7:0] min_i,
  // Result.
  output logic [7:0] res_o,
  output logic wrap_o
);
  always_comb begin
    wrap_o = (val_i >= max_i);
    if (wrap_o) begin
      res_o = min_i;
    end else if (val_i[3:0] == 4'h9) begin
      res_o = {val_i[7:4] + 4'h1, 4'h0};
    end else begin
      res_o = {val_i[7:4], val_i[3:0] + 4'h1};
    end
  end
endmodule : bcd_inc
`default_nettype wire

// [src/power_guard.sv]
/*
  Power-fail gate: blocks access while the supply is low and for the
  recovery interval after, and drives the power-on reset output.
  Assumes the supply comparator arrives synchronous to clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module power_guard
  import rtc_pkg::*;
#(
  parameter int RECOVERY = RECOVERY_CYCLES,
  parameter int POR_LEN = POR_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Supply monitor.
  input wire logic supply_low_i,
  // Status.
  output logic access_ok_o,
  output logic por_b_o
);
  logic [31:0] rec_cnt_reg, rec_cnt_next;
  logic ok_reg, ok_next;
  logic por_reg, por_next;

  always_comb begin
    rec_cnt_next = rec_cnt_reg;
    ok_next = ok_reg;
    por_next = por_reg;
    if (supply_low_i) begin
      rec_cnt_next = '0;
      ok_next = 1'b0;
    end else if (rec_cnt_reg < 32'(RECOVERY)) begin
      rec_cnt_next = rec_cnt_reg + 32'h0000_0001;
    end else begin
      ok_next = 1'b1;
    end
    por_next = !supply_low_i && (rec_cnt_reg >= 32'(POR_LEN));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rec_cnt_reg <= '0;
      ok_reg <= 1'b0;
      por_reg <= 1'b0;
    end else begin
      rec_cnt_reg <= rec_cnt_next;
      ok_reg <= ok_next;
      por_reg <= por_next;
    end
  end

  assign access_ok_o = ok_reg;
  assign por_b_o = por_reg;
endmodule : power_guard
`default_nettype wire

// [src/nv_timekeeping_ram_rtc.sv]
/*
  Timekeeping RAM: 8k x 8 byte store with BCD clock in the top eight bytes.
  Assumes SRAM-style strobes synchronous to clk_i; the oscillator tick is
  divided down from clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module nv_timekeeping_ram_rtc
  import rtc_pkg::*;
#(
  parameter int RECOVERY = RECOVERY_CYCLES,
  parameter int POR_LEN = POR_CYCLES,
  parameter int TICK_DIV = HALF_TEST_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Byte-wide host port.
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic chip_sel_n_i,
  input wire logic chip_sel_hi_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  // Power and battery.
  input wire logic supply_low_i,
  input wire logic battery_low_i,
  output logic power_on_rst_b_o
);
  localparam int NREG = 8;
  localparam int IDX_DAY = 4;
  localparam int IDX_DATE = 5;
  localparam int IDX_MONTH = 6;
  typedef logic [7:0] byte_t;

  byte_t mem [0:(1<<ADDR_W)-1];
  byte_t cnt_reg [NREG], cnt_next [NREG];
  byte_t vis_reg [NREG], vis_next [NREG];
  byte_t inc_res [NREG];
  logic inc_wrap [NREG];
  byte_t inc_max [NREG], inc_min [NREG];
  byte_t inc_val [NREG];
  logic [31:0] div_reg, div_next;
  logic [9:0] tick_reg, tick_next;
  logic ft_reg, ft_next;
  logic wh_prev_reg, wh_prev_next;
  byte_t dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic por_q;
  logic access_ok;
  logic sel, wr, rd, is_clk, sec_tick, ft_tick;
  logic [2:0] idx;
  byte_t mem_rd;
  logic leap;
  byte_t last_day;

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[2:0];
  endfunction : reg_index

  function automatic logic in_clock(input logic [ADDR_W-1:0] a);
    in_clock = (a[ADDR_W-1:3] == CLOCK_BASE);
  endfunction : in_clock

  // Day, date and month restart at one, every other byte at zero.
  function automatic byte_t reset_value(input int i);
    if (i == IDX_DAY || i == IDX_DATE || i == IDX_MONTH) begin
      reset_value = BCD_ONE;
    end else begin
      reset_value = BCD_ZERO;
    end
  endfunction : reset_value

  // Power-fail gate.
  power_guard #(.RECOVERY(RECOVERY), .POR_LEN(POR_LEN)) u_guard (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .supply_low_i(supply_low_i),
    .access_ok_o(access_ok),
    .por_b_o(por_q)
  );

  // One BCD incrementer per clock byte.
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_inc
      bcd_inc u_inc (
        .val_i(inc_val[g]),
        .max_i(inc_max[g]),
        .min_i(inc_min[g]),
        .res_o(inc_res[g]),
        .wrap_o(inc_wrap[g])
      );
    end
  endgenerate

  assign sel = access_ok && !chip_sel_n_i && chip_sel_hi_i;
  assign wr = sel && !write_en_n_i;
  assign rd = sel && write_en_n_i && !out_en_n_i;
  assign is_clk = in_clock(addr_i);
  assign idx = reg_index(addr_i);
  assign mem_rd = mem[addr_i];

  // Leap years divisible by four hold through 2099.
  assign leap = !cnt_reg[7][4] ? (cnt_reg[7][1:0] == 2'b00)
                               : (cnt_reg[7][1:0] == 2'b10);
  always_comb begin
    unique case (cnt_reg[6] & MASK_MONTH)
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      MONTH_FEB: last_day = leap ? 8'h29 : 8'h28;
      default: last_day = 8'h31;
    endcase
  end

  // Control and flag bits are kept out of the BCD increment.
  always_comb begin
    inc_val[0] = cnt_reg[0] & MASK_CENT;
    inc_val[1] = cnt_reg[1] & MASK_SEC;
    inc_val[2] = cnt_reg[2] & MASK_MIN;
    inc_val[3] = cnt_reg[3] & MASK_HOUR;
    inc_val[4] = cnt_reg[4] & MASK_DAY;
    inc_val[5] = cnt_reg[5] & MASK_DATE;
    inc_val[6] = cnt_reg[6] & MASK_MONTH;
    inc_val[7] = cnt_reg[7];
  end

  always_comb begin
    inc_max[0] = MAX_CENT;
    inc_min[0] = BCD_ZERO;
    inc_max[1] = MAX_SEC;
    inc_min[1] = BCD_ZERO;
    inc_max[2] = MAX_SEC;
    inc_min[2] = BCD_ZERO;
    inc_max[3] = MAX_HOUR;
    inc_min[3] = BCD_ZERO;
    inc_max[4] = MAX_DAY;
    inc_min[4] = BCD_ONE;
    inc_max[5] = last_day;
    inc_min[5] = BCD_ONE;
    inc_max[6] = MAX_MONTH;
    inc_min[6] = BCD_ONE;
    inc_max[7] = MAX_YEAR;
    inc_min[7] = BCD_ZERO;
  end

  // Divider for the 512 Hz toggle and the one-second tick.
  assign ft_tick = !cnt_reg[1][BIT_OSC_STOP] &&
                   (div_reg >= 32'(TICK_DIV - 1));
  assign sec_tick = ft_tick && (tick_reg == 10'(TICKS_PER_SEC - 1));

  always_comb begin
    div_next = ft_tick ? '0 : div_reg + 32'h0000_0001;
    tick_next = ft_tick ? tick_reg + 10'h001 : tick_reg;
    ft_next = ft_reg;
    if (cnt_reg[1][BIT_OSC_STOP]) begin
      div_next = div_reg;
      tick_next = tick_reg;
    end else if (ft_tick) begin
      ft_next = !ft_reg;
    end
  end

  // Counting registers, visible copy and write-hold transfer.
  always_comb begin
    logic carry;
    logic wh, rh;
    carry = 1'b0;
    wh = vis_reg[0][BIT_WRITE_HOLD];
    rh = vis_reg[0][BIT_READ_HOLD];
    for (int i = 0; i < NREG; i++) begin
      cnt_next[i] = cnt_reg[i];
      vis_next[i] = vis_reg[i];
    end
    wh_prev_next = wh;
    if (sec_tick && !wh) begin
      carry = 1'b1;
      cnt_next[1] = {cnt_reg[1][7], inc_res[1][6:0]};
      if (inc_wrap[1]) begin
        cnt_next[2] = inc_res[2];
        if (inc_wrap[2]) begin
          cnt_next[3] = inc_res[3];
          if (inc_wrap[3]) begin
            cnt_next[4] = {cnt_reg[4][7:3], inc_res[4][2:0]};
            cnt_next[5] = inc_res[5];
            if (inc_wrap[5]) begin
              cnt_next[6] = inc_res[6];
              if (inc_wrap[6]) begin
                cnt_next[7] = inc_res[7];
                if (inc_wrap[7]) begin
                  cnt_next[0] = {cnt_reg[0][7:6], inc_res[0][5:0]};
                end
              end
            end
          end
        end
      end
    end
    if (wh_prev_reg && !wh) begin
      for (int i = 0; i < NREG; i++) begin
        cnt_next[i] = vis_reg[i];
      end
      cnt_next[0][BIT_WRITE_HOLD] = 1'b0;
    end
    cnt_next[1][BIT_OSC_STOP] = vis_reg[1][BIT_OSC_STOP];
    cnt_next[4][BIT_FREQ_TEST] = vis_reg[4][BIT_FREQ_TEST];
    if (!wh && !rh) begin
      for (int i = 0; i < NREG; i++) begin
        vis_next[i] = cnt_next[i];
      end
      vis_next[0][7:6] = vis_reg[0][7:6];
    end
    if (!carry && !wh && !rh && vis_reg[4][BIT_FREQ_TEST] &&
        !cnt_reg[1][BIT_OSC_STOP]) begin
      vis_next[1][0] = ft_reg;
    end
    if (wr && is_clk) begin
      vis_next[idx] = data_i;
    end
  end

  always_comb begin
    dout_next = mem_rd;
    if (is_clk) begin
      dout_next = vis_reg[idx];
      if (idx == 3'(ADDR_DAY[2:0])) begin
        dout_next[BIT_BATT_LOW] = battery_low_i;
      end
    end
    oe_next = rd;
  end

  always_ff @(posedge clk_i) begin
    if (wr && !is_clk) begin
      mem[addr_i] <= data_i;
    end
  end

  // Divider group.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      div_reg <= '0;
      tick_reg <= '0;
      ft_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
      ft_reg <= ft_next;
    end
  end

  // Clock byte registers.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NREG; i++) begin
        cnt_reg[i] <= reset_value(i);
        vis_reg[i] <= reset_value(i);
      end
      wh_prev_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      vis_reg <= vis_next;
      wh_prev_reg <= wh_prev_next;
    end
  end

  // Read port and power-on reset output.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dout_reg <= '0;
      oe_reg <= 1'b0;
      power_on_rst_b_o <= 1'b0;
    end else begin
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      power_on_rst_b_o <= por_q;
    end
  end

  assign data_o = dout_reg;
  assign data_oe_o = oe_reg;
endmodule : nv_timekeeping_ram_rtc
`default_nettype wire

// [verif/rtc_monitor.sv]
/* Checker for the byte-wide port and power gating.
   Bound to the top module; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module rtc_monitor
  import rtc_pkg::*;
#(
  parameter int RECOVERY = 50,
  parameter int POR_LEN = 10
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic chip_sel_n_i,
  input wire logic chip_sel_hi_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic data_oe_o,
  input wire logic supply_low_i,
  input wire logic power_on_rst_b_o
);
  // Counts cycles of good supply since reset or the last drop.
  int good_reg;
  int good_next;
  always_comb begin
    good_next = good_reg;
    if (good_reg < RECOVERY + POR_LEN + 8) begin
      good_next = good_reg + 1;
    end
    if (supply_low_i) begin
      good_next = 0;
    end
  end
  always_ff @(posedge clk_i) begin
    good_reg <= rst_b_i ? good_next : 0;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence read_s;
    !chip_sel_n_i && chip_sel_hi_i && write_en_n_i && !out_en_n_i;
  endsequence
  sequence low_s;
    supply_low_i ##1 supply_low_i;
  endsequence
  supply_block_a: assert property (low_s |=> !data_oe_o)
    else $error("drive while supply low");
  recovery_block_a: assert property (
    good_reg < RECOVERY - 1 |=> !data_oe_o)
    else $error("drive during recovery");
  read_drive_a: assert property (
    (good_reg > RECOVERY + 3) and read_s |=> data_oe_o)
    else $error("read not driven");
  oe_gate_a: assert property (out_en_n_i |=> !data_oe_o)
    else $error("drive without output enable");
  deselect_quiet_a: assert property (
    chip_sel_n_i || !chip_sel_hi_i |=> !data_oe_o)
    else $error("drive while deselected");
  write_quiet_a: assert property (!write_en_n_i |=> !data_oe_o)
    else $error("drive during write");
  por_rise_a: assert property (
    $rose(power_on_rst_b_o) |-> good_reg >= POR_LEN)
    else $error("power-on reset released early");
  por_bound_a: assert property (
    good_reg == POR_LEN + 4 |-> power_on_rst_b_o)
    else $error("power-on reset held too long");
endmodule : rtc_monitor
bind nv_timekeeping_ram_rtc rtc_monitor #(
  .RECOVERY(RECOVERY),
  .POR_LEN(POR_LEN)
) mon (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .chip_sel_n_i(chip_sel_n_i),
  .chip_sel_hi_i(chip_sel_hi_i),
  .out_en_n_i(out_en_n_i),
  .write_en_n_i(write_en_n_i),
  .data_oe_o(data_oe_o),
  .supply_low_i(supply_low_i),
  .power_on_rst_b_o(power_on_rst_b_o)
);
`default_nettype wire

// [verif/host_model.sv]
/* Host on the byte-wide port: single-byte reads and writes.
   Assumes one bench process calls its tasks. */
`timescale 1ns/1ns
`default_nettype none
module host_model
  import rtc_pkg::*;
(
  input wire logic clk_i,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic roe_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic chip_sel_n_o,
  output logic chip_sel_hi_o,
  output logic out_en_n_o,
  output logic write_en_n_o,
  output logic [DATA_W-1:0] wdata_o
);
  logic sel_hi = 1'b1;
  logic oe_n = 1'b0;
  // Released data lines show the inverse of the last value.
  task automatic idle();
    chip_sel_n_o = 1'b1;
    write_en_n_o = 1'b1;
    out_en_n_o = 1'b1;
    wdata_o = ~wdata_o;
  endtask : idle
  initial begin
    addr_o = '0;
    wdata_o = '0;
    chip_sel_hi_o = 1'b0;
    chip_sel_n_o = 1'b1;
    write_en_n_o = 1'b1;
    out_en_n_o = 1'b1;
  end
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    chip_sel_n_o = 1'b0;
    chip_sel_hi_o = sel_hi;
    write_en_n_o = 1'b0;
    @(posedge clk_i);
    #1;
    idle();
  endtask : wr
  task automatic rd(input logic [12:0] a, output logic [7:0] d,
                    output logic oe);
    @(posedge clk_i);
    #1;
    addr_o = a;
    chip_sel_n_o = 1'b0;
    chip_sel_hi_o = 1'b1;
    out_en_n_o = oe_n;
    @(posedge clk_i);
    @(negedge clk_i);
    d = rdata_i;
    oe = roe_i;
    @(posedge clk_i);
    #1;
    idle();
  endtask : rd
endmodule : host_model
`default_nettype wire

// [verif/testbench.sv]
/* Self-checking bench for the timekeeping RAM.
   Assumes short recovery, reset and tick counts. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rtc_pkg::*;
  localparam int REC = 50;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic supply_low_i = 1'b0;
  logic battery_low_i = 1'b0;
  logic [12:0] addr;
  logic cs_n, cs_hi, oe_n, we_n, oe, por_b, f;
  logic [7:0] wdata, rdata, d;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int tog = 0;
  logic [7:0] sec_prev;
  logic [12:0] row_a [4] = '{13'h0000, 13'h1FF7, 13'h1555, 13'h0AAA};
  logic [7:0] row_d [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
  logic [7:0] ck_d [7] = '{8'h59, 8'h59, 8'h23, 8'h03, 8'h28, 8'h02, 8'h24};
  logic [7:0] ck_n [7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h29, 8'h02, 8'h24};
  always #5 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .rdata_i(rdata), .roe_i(oe),
    .addr_o(addr), .chip_sel_n_o(cs_n), .chip_sel_hi_o(cs_hi),
    .out_en_n_o(oe_n), .write_en_n_o(we_n), .wdata_o(wdata));
  nv_timekeeping_ram_rtc #(.RECOVERY(REC), .POR_LEN(10), .TICK_DIV(4)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .chip_sel_n_i(cs_n),
    .chip_sel_hi_i(cs_hi), .out_en_n_i(oe_n), .write_en_n_i(we_n),
    .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
    .supply_low_i(supply_low_i), .battery_low_i(battery_low_i),
    .power_on_rst_b_o(por_b));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [12:0] a, input logic [7:0] exp);
    host.rd(a, d, f);
    chk(d, exp);
  endtask : rchk
  task automatic close_out();
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    chk({7'h0, por_b}, 8'h00);
    host.rd(13'h0000, d, f);
    chk({7'h0, f}, 8'h00);
    repeat (REC + 5) @(posedge clk_i);
    #1;
    chk({7'h0, por_b}, 8'h01);
    for (int i = 0; i < 4; i++) host.wr(row_a[i], row_d[i]);
    for (int i = 0; i < 4; i++) rchk(row_a[i], row_d[i]);
    host.sel_hi = 1'b0;
    host.wr(13'h0000, 8'hFF);
    host.sel_hi = 1'b1;
    rchk(13'h0000, 8'hA5);
    host.oe_n = 1'b1;
    host.rd(13'h0000, d, f);
    host.oe_n = 1'b0;
    chk({7'h0, f}, 8'h00);
    supply_low_i = 1'b1;
    host.wr(13'h0000, 8'h99);
    host.rd(13'h0000, d, f);
    chk({7'h0, f}, 8'h00);
    supply_low_i = 1'b0;
    host.wr(13'h0000, 8'h99);
    repeat (REC + 5) @(posedge clk_i);
    rchk(13'h0000, 8'hA5);
    host.wr(ADDR_CTRL, 8'hA0);
    for (int i = 0; i < 7; i++) host.wr(ADDR_SEC + 13'(i), ck_d[i]);
    host.wr(ADDR_CTRL, 8'h20);
    d = '0;
    for (int i = 0; i < 3000 && d !== 8'h29; i++) host.rd(ADDR_DATE, d, f);
    chk(d, 8'h29);
    for (int i = 0; i < 7; i++) rchk(ADDR_SEC + 13'(i), ck_n[i]);
    rchk(ADDR_CTRL, 8'h20);
    host.wr(ADDR_CTRL, 8'h60);
    repeat (4200) @(posedge clk_i);
    rchk(ADDR_SEC, 8'h00);
    host.wr(ADDR_CTRL, 8'h20);
    host.rd(ADDR_SEC, d, f);
    chk(d, 8'h01);
    battery_low_i = 1'b1;
    rchk(ADDR_DAY, 8'h84);
    host.wr(ADDR_CTRL, 8'hA0);
    host.wr(ADDR_SEC, 8'hB0);
    host.wr(ADDR_CTRL, 8'h20);
    repeat (4200) @(posedge clk_i);
    host.rd(ADDR_SEC, d, f);
    chk(d & MASK_SEC, 8'h30);
    host.wr(ADDR_CTRL, 8'hA0);
    host.wr(ADDR_SEC, 8'h00);
    host.wr(ADDR_DAY, 8'h44);
    host.wr(ADDR_CTRL, 8'h20);
    rchk(ADDR_DAY, 8'hC4);
    host.rd(ADDR_SEC, sec_prev, f);
    for (int i = 0; i < 8; i++) begin
      host.rd(ADDR_SEC, d, f);
      if (d[0] !== sec_prev[0]) begin
        tog++;
      end
      sec_prev = d;
    end
    chk(d & 8'hFE, 8'h00);
    chk({7'h0, tog > 0}, 8'h01);
    rst_b_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk({6'h0, por_b, oe}, 8'h00);
    @(posedge clk_i);
    #1;
    rst_b_i = 1'b1;
    host.rd(ADDR_DATE, d, f);
    chk({7'h0, f}, 8'h00);
    repeat (REC + 5) @(posedge clk_i);
    #1;
    chk({7'h0, por_b}, 8'h01);
    rchk(ADDR_DATE, 8'h01);
    close_out();
  end
endmodule : testbench
`default_nettype wire
